// ---- core/eps_pkg.sv ----
/*
 Constants, state codes and timing figures for the programmer that drives
 a byte-wide UV EPROM through its address, data and control pins.
 Assumes a 100 MHz system clock; voltages are selected by external switches.
*/
package eps_pkg;
   // ==========================================================
   // Geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam logic [19:0] ADDR_FIRST = 20'h00000;
   localparam logic [19:0] ADDR_LAST = 20'hFFFFF;
   localparam logic [19:0] ADDR_ZERO = 20'h00000;
   localparam int ID_MODE_BIT = 9;
   localparam int ID_SEL_BIT = 0;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int PULSE_NOM_US = 50;
   localparam int PULSE_MIN_US = 47;
   localparam int PULSE_MAX_US = 53;
   localparam int SETUP_US = 2;
   localparam int PULSE_CYC = PULSE_NOM_US * CLK_MHZ;
   localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
   localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
   localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
   localparam int TMR_W = 16;
   // ==========================================================
   // Retry budget
   localparam int MAX_PULSES = 10;
   localparam logic [3:0] PULSE_BUDGET = 4'hA;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // ==========================================================
   // Sequencer states
   typedef enum logic [3:0] {
      EPS_IDLE = 4'b0000,
      EPS_PWR_UP = 4'b0001,
      EPS_VPP_UP = 4'b0010,
      EPS_P1_SET = 4'b0011,
      EPS_P1_PULSE = 4'b0100,
      EPS_V_PULSE = 4'b0101,
      EPS_V_READ = 4'b0110,
      EPS_V_CHECK = 4'b0111,
      EPS_VPP_DOWN = 4'b1000,
      EPS_PWR_DOWN = 4'b1001,
      EPS_RB_READ = 4'b1010,
      EPS_RB_CHECK = 4'b1011,
      EPS_ID_READ = 4'b1100,
      EPS_DONE = 4'b1101
   } eps_state_e;
   // ==========================================================
   // Shared arithmetic
   function automatic logic [19:0] eps_next_addr(input logic [19:0] a);
      eps_next_addr = a + 20'h00001;
   endfunction
endpackage

// ---- core/eps_sequencer.sv ----
/*
 Programmer for a 1M x 8 UV EPROM: programs every byte with the rapid
 pulse-and-verify algorithm, reads back the bytes up to the first mismatch when no byte failed verify, and reads the two
 identification bytes. Assumes the source data arrives combinationally from a
 same-clock store addressed by src_addr, and external voltage switches follow
 the vcc/vpp/id request outputs; the device data bus returns through pins.
*/
`timescale 1ns/10ps
module eps_sequencer
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Commands
   input wire logic start_prog,
   input wire logic start_id,
   // Source data
   output logic [19:0] src_addr,
   input wire logic [7:0] src_data,
   // Device pins
   output logic [19:0] addr_out,
   output logic chip_en_n,
   output logic out_en_n,
   output logic [7:0] data_outputs_o,
   output logic data_outputs_oe,
   input wire logic [7:0] data_outputs_i,
   // Voltage switch requests
   output logic vcc_prog,
   output logic vpp_on,
   output logic id_select_voltage,
   // Status
   output logic busy,
   output logic done,
   output logic pass,
   output logic [19:0] fail_addr,
   output logic [7:0] id_maker,
   output logic [7:0] id_type
);
   eps_pkg::eps_state_e state;
   eps_pkg::eps_state_e next_state;
   logic [7:0] din_meta;
   logic [7:0] din_sync;
   logic [3:0] pulses;
   logic id_byte;
   logic tmr_load;
   logic [15:0] tmr_count;
   logic tmr_done;
   logic fail_flag;

   // ==========================================================
   // Pin synchroniser
   always_ff @(posedge clk)
   begin
      din_meta <= data_outputs_i;
      din_sync <= din_meta;
   end

   // ==========================================================
   // Decode
   wire at_last = (addr_out == eps_pkg::ADDR_LAST);
   wire match = (din_sync == src_data);
   wire budget_out = (pulses == eps_pkg::PULSE_BUDGET);
   wire [19:0] addr_inc = eps_pkg::eps_next_addr(addr_out);
   wire [19:0] id_addr = {{(eps_pkg::ADDR_W - 10){1'b0}}, 1'b1, 8'h00, id_byte};
   wire enter = (state != next_state);

   eps_timer u_tmr
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .count(tmr_count),
      .expired(tmr_done)
   );

   wire id_reload = (state == eps_pkg::EPS_ID_READ) && tmr_done && !id_byte;
   assign tmr_load = enter || id_reload;
   assign tmr_count = (next_state == eps_pkg::EPS_P1_PULSE ||
                       next_state == eps_pkg::EPS_V_PULSE) ? 16'(eps_pkg::PULSE_CYC)
                                                          : 16'(eps_pkg::SETUP_CYC);

   // ==========================================================
   // Next state
   always_comb
   begin
      next_state = state;
      case (state)
         eps_pkg::EPS_IDLE:
            if (start_prog || start_id)
               next_state = eps_pkg::EPS_PWR_UP;
         eps_pkg::EPS_PWR_UP:
            if (tmr_done)
               next_state = id_select_voltage ? eps_pkg::EPS_ID_READ
                                              : eps_pkg::EPS_VPP_UP;
         eps_pkg::EPS_VPP_UP:
            if (tmr_done)
               next_state = eps_pkg::EPS_P1_SET;
         eps_pkg::EPS_P1_SET:
            if (tmr_done)
               next_state = eps_pkg::EPS_P1_PULSE;
         eps_pkg::EPS_P1_PULSE:
            if (tmr_done)
               next_state = at_last ? eps_pkg::EPS_V_READ : eps_pkg::EPS_P1_SET;
         eps_pkg::EPS_V_PULSE:
            if (tmr_done)
               next_state = eps_pkg::EPS_V_READ;
         eps_pkg::EPS_V_READ:
            if (tmr_done)
               next_state = eps_pkg::EPS_V_CHECK;
         eps_pkg::EPS_V_CHECK:
            if (match && at_last)
               next_state = eps_pkg::EPS_VPP_DOWN;
            else if (match)
               next_state = eps_pkg::EPS_V_READ;
            else if (budget_out)
               next_state = eps_pkg::EPS_VPP_DOWN;
            else
               next_state = eps_pkg::EPS_V_PULSE;
         eps_pkg::EPS_VPP_DOWN:
            if (tmr_done)
               next_state = eps_pkg::EPS_PWR_DOWN;
         eps_pkg::EPS_PWR_DOWN:
            if (tmr_done)
               next_state = fail_flag ? eps_pkg::EPS_DONE : eps_pkg::EPS_RB_READ;
         eps_pkg::EPS_RB_READ:
            if (tmr_done)
               next_state = eps_pkg::EPS_RB_CHECK;
         eps_pkg::EPS_RB_CHECK:
            if (!match || at_last)
               next_state = eps_pkg::EPS_DONE;
            else
               next_state = eps_pkg::EPS_RB_READ;
         eps_pkg::EPS_ID_READ:
            if (tmr_done && id_byte)
               next_state = eps_pkg::EPS_DONE;
         eps_pkg::EPS_DONE:
            next_state = eps_pkg::EPS_IDLE;
         default:
            next_state = eps_pkg::EPS_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state <= eps_pkg::EPS_IDLE;
      else
         state <= next_state;
   end

   // ==========================================================
   // Pin drive
   wire in_pulse = (state == eps_pkg::EPS_P1_PULSE) || (state == eps_pkg::EPS_V_PULSE);
   wire in_read = (state == eps_pkg::EPS_V_READ) || (state == eps_pkg::EPS_V_CHECK) ||
                  (state == eps_pkg::EPS_RB_READ) || (state == eps_pkg::EPS_RB_CHECK) ||
                  (state == eps_pkg::EPS_ID_READ);
   wire vpp_phase = (state == eps_pkg::EPS_VPP_UP) || (state == eps_pkg::EPS_P1_SET) ||
                    (state == eps_pkg::EPS_P1_PULSE) || (state == eps_pkg::EPS_V_PULSE) ||
                    (state == eps_pkg::EPS_V_READ) || (state == eps_pkg::EPS_V_CHECK);
   wire prog_phase = vpp_phase || (state == eps_pkg::EPS_PWR_UP && !id_select_voltage) ||
                     (state == eps_pkg::EPS_VPP_DOWN);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         chip_en_n <= 1'b1;
         out_en_n <= 1'b1;
         data_outputs_oe <= 1'b0;
         data_outputs_o <= 8'h00;
         vpp_on <= 1'b0;
         vcc_prog <= 1'b0;
      end
      else
      begin
         chip_en_n <= !(in_pulse || in_read) || enter;
         out_en_n <= !(in_read && !vpp_phase) && !(state == eps_pkg::EPS_V_READ ||
                     state == eps_pkg::EPS_V_CHECK);
         data_outputs_oe <= in_pulse || (state == eps_pkg::EPS_P1_SET);
         data_outputs_o <= src_data;
         vpp_on <= vpp_phase && (state != eps_pkg::EPS_V_READ) &&
                   (state != eps_pkg::EPS_V_CHECK);
         vcc_prog <= prog_phase;
      end
   end

   // ==========================================================
   // Address, counters and results
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         addr_out <= eps_pkg::ADDR_ZERO;
         src_addr <= eps_pkg::ADDR_ZERO;
         pulses <= eps_pkg::CNT_ZERO;
         id_byte <= 1'b0;
         id_select_voltage <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         pass <= 1'b0;
         fail_flag <= 1'b0;
         fail_addr <= eps_pkg::ADDR_ZERO;
         id_maker <= 8'h00;
         id_type <= 8'h00;
      end
      else
      begin
         done <= (state == eps_pkg::EPS_DONE);
         busy <= (next_state != eps_pkg::EPS_IDLE);
         if (state == eps_pkg::EPS_IDLE && (start_prog || start_id))
         begin
            addr_out <= eps_pkg::ADDR_FIRST;
            src_addr <= eps_pkg::ADDR_FIRST;
            id_select_voltage <= start_id && !start_prog;
            id_byte <= 1'b0;
            fail_flag <= 1'b0;
            pass <= 1'b0;
            pulses <= eps_pkg::CNT_ZERO;
         end
         if (state == eps_pkg::EPS_PWR_UP && id_select_voltage && tmr_done)
            addr_out <= id_addr;
         if (state == eps_pkg::EPS_ID_READ && tmr_done)
         begin
            if (id_byte)
               id_type <= din_sync;
            else
               id_maker <= din_sync;
            id_byte <= 1'b1;
            addr_out <= {{(eps_pkg::ADDR_W - 10){1'b0}}, 1'b1, 8'h00, 1'b1};
         end
         if (state == eps_pkg::EPS_P1_PULSE && tmr_done)
         begin
            addr_out <= at_last ? eps_pkg::ADDR_FIRST : addr_inc;
            src_addr <= at_last ? eps_pkg::ADDR_FIRST : addr_inc;
         end
         if (state == eps_pkg::EPS_V_PULSE && tmr_done)
            pulses <= pulses + eps_pkg::CNT_ONE;
         if (state == eps_pkg::EPS_V_CHECK)
         begin
            if (match)
            begin
               pulses <= eps_pkg::CNT_ZERO;
               addr_out <= at_last ? eps_pkg::ADDR_FIRST : addr_inc;
               src_addr <= at_last ? eps_pkg::ADDR_FIRST : addr_inc;
            end
            else if (budget_out)
            begin
               fail_flag <= 1'b1;
               fail_addr <= addr_out;
            end
         end
         if (state == eps_pkg::EPS_RB_CHECK)
         begin
            if (!match)
            begin
               fail_flag <= 1'b1;
               fail_addr <= addr_out;
            end
            else if (!at_last)
            begin
               addr_out <= addr_inc;
               src_addr <= addr_inc;
            end
         end
         if (state == eps_pkg::EPS_DONE)
         begin
            pass <= !fail_flag;
            id_select_voltage <= 1'b0;
            addr_out <= eps_pkg::ADDR_ZERO;
         end
      end
   end

   // ==========================================================
   // Checks
   logic [15:0] low_run;
   always_ff @(posedge clk)
   begin
      if (sys_rst || chip_en_n || !vpp_on)
         low_run <= 16'h0000;
      else
         low_run <= low_run + 16'h0001;
   end

   pulse_max_a: assert property (@(posedge clk) disable iff (sys_rst)
      low_run <= 16'(eps_pkg::PULSE_MAX_CYC))
      else $error("program pulse too long");
   pulse_min_a: assert property (@(posedge clk) disable iff (sys_rst)
      ($rose(chip_en_n) && $past(vpp_on) && $past(low_run) != 16'h0000)
      |-> $past(low_run) >= 16'(eps_pkg::PULSE_MIN_CYC - 1))
      else $error("program pulse too short");
   supply_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      vpp_on |-> vcc_prog)
      else $error("vpp without programming supply");
   ce_needs_supply_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!chip_en_n && vpp_on) |-> vcc_prog)
      else $error("pulse without raised supply");
   budget_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
      pulses <= eps_pkg::PULSE_BUDGET)
      else $error("pulse budget exceeded");
   fail_end_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == eps_pkg::EPS_V_CHECK && !match && budget_out)
      |=> state == eps_pkg::EPS_VPP_DOWN)
      else $error("exhausted byte did not end programming");
   readback_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == eps_pkg::EPS_RB_READ) |-> (!vpp_on && !vcc_prog))
      else $error("read back under programming voltages");
   id_other_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == eps_pkg::EPS_ID_READ) |-> (addr_out[19:10] == 10'h000 &&
      addr_out[8:1] == 8'h00 && id_select_voltage))
      else $error("id mode address lines not low");
   start_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == eps_pkg::EPS_VPP_UP) |-> addr_out == eps_pkg::ADDR_FIRST)
      else $error("programming did not start at lowest address");

   prog_done_c: cover property (@(posedge clk) disable iff (sys_rst)
      $rose(done) && pass);
   prog_fail_c: cover property (@(posedge clk) disable iff (sys_rst)
      $rose(done) && !pass);
   retry_c: cover property (@(posedge clk) disable iff (sys_rst)
      state == eps_pkg::EPS_V_PULSE);
   id_read_c: cover property (@(posedge clk) disable iff (sys_rst)
      state == eps_pkg::EPS_ID_READ && id_byte);
endmodule

// ---- core/eps_timer.sv ----
/*
 Down-counting delay timer used for pulse and setup intervals.
 Assumes load and the count come from logic on the same clock.
*/
`timescale 1ns/10ps
module eps_timer
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic load,
   input wire logic [15:0] count,
   // Status
   output logic expired
);
   logic [15:0] remain;
   wire at_zero = (remain == 16'h0000);

   // ==========================================================
   // Counter
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         remain <= 16'h0000;
      else if (load)
         remain <= count;
      else if (!at_zero)
         remain <= remain - 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         expired <= 1'b0;
      else
         expired <= !load && (remain == 16'h0001);
   end
endmodule

// ---- verif/eps_rom_model.sv ----
/*
 Behavioural model of the byte-wide UV EPROM that the programmer drives.
 Assumes the programmer's pins and voltage requests are sampled on clk.
*/
`timescale 1ns/10ps
module eps_rom_model
#(
   parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
   parameter logic [7:0] TYPE_CODE = 8'hC5 // Arbitrary value
)
(
   // Clock
   input wire logic clk,
   // Device pins
   input wire logic [19:0] addr,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic [7:0] prog_data,
   input wire logic prog_oe,
   output logic [7:0] bus_level,
   // Voltage levels
   input wire logic vcc_prog,
   input wire logic vpp_on,
   input wire logic hv_id,
   // Observation
   output int n_bad,
   output int n_pulses,
   output logic [19:0] last_addr
);
   // ==========================================================
   // Mode decode
   logic [7:0] mem [logic [19:0]];
   logic [7:0] last = 8'h00;
   logic [7:0] rd_val;
   logic reading;
   logic id_mode;
   logic pgm;
   logic prev_pgm = 1'b0;
   int width = 0;
   logic [19:0] pulse_addr = 20'h00000;
   logic [7:0] pulse_data = 8'hFF;
   assign reading = !chip_en_n && !out_en_n && !vpp_on;
   assign pgm = !chip_en_n && vpp_on;
   assign id_mode = hv_id && ((addr & 20'hFFDFE) == 20'h00000);
   always @*
   begin
      if (id_mode)
         rd_val = addr[0] ? TYPE_CODE : MAKER_CODE;
      else if (mem.exists(addr))
         rd_val = mem[addr];
      else
         rd_val = 8'hFF;
      if (prog_oe)
         bus_level = prog_data;
      else if (reading)
         bus_level = rd_val;
      else
         bus_level = ~last;
   end
   // ==========================================================
   // Programming and checks
   initial
   begin
      n_bad = 0;
      n_pulses = 0;
      last_addr = 20'h00000;
   end
   always @(posedge clk)
   begin
      last <= bus_level;
      prev_pgm <= pgm;
      if (vpp_on && !vcc_prog)
         n_bad = n_bad + 1;
      if (prog_oe && reading)
         n_bad = n_bad + 1;
      if (pgm)
      begin
         width = width + 1;
         pulse_addr = addr;
         pulse_data = prog_data;
      end
      if (prev_pgm && !pgm)
      begin
         if (width < eps_pkg::PULSE_MIN_CYC || width > eps_pkg::PULSE_MAX_CYC)
            n_bad = n_bad + 1;
         mem[pulse_addr] = (mem.exists(pulse_addr) ? mem[pulse_addr] : 8'hFF) & pulse_data;
         n_pulses = n_pulses + 1;
         last_addr = pulse_addr;
         width = 0;
      end
   end
endmodule

// ---- verif/eps_sequencer_bench.sv ----
/*
 Self-checking bench for the EPROM programmer: reset, identification read,
 start of programming and a reset in mid-run.
 Assumes the device model eps_rom_model on the far side.
*/
`timescale 1ns/10ps
module eps_sequencer_bench;
   // ==========================================================
   // Signals
   localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
   localparam logic [7:0] DEV_TYPE = 8'hC5; // Arbitrary value
   localparam int LIMIT = 60000;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic start_prog = 1'b0;
   logic start_id = 1'b0;
   logic [19:0] src_addr;
   logic [7:0] src_data;
   logic [19:0] addr_out;
   logic chip_en_n;
   logic out_en_n;
   logic [7:0] data_o;
   logic data_oe;
   logic [7:0] data_i;
   logic vcc_prog;
   logic vpp_on;
   logic id_select_voltage;
   logic busy;
   logic done;
   logic pass;
   logic [19:0] fail_addr;
   logic [7:0] id_maker;
   logic [7:0] id_type;
   logic [19:0] last_addr;
   int n_bad;
   int n_pulses;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   int bad_data = 0;
   int bad_id = 0;
   int n_reads = 0;
   always #5 clk = ~clk;
   assign src_data = src_addr[7:0] ^ 8'h5A;
   // ==========================================================
   // Instances
   eps_sequencer eps_sequencer_inst (.clk(clk), .sys_rst(sys_rst), .start_prog(start_prog),
      .start_id(start_id), .src_addr(src_addr), .src_data(src_data), .addr_out(addr_out),
      .chip_en_n(chip_en_n), .out_en_n(out_en_n), .data_outputs_o(data_o),
      .data_outputs_oe(data_oe), .data_outputs_i(data_i), .vcc_prog(vcc_prog),
      .vpp_on(vpp_on), .id_select_voltage(id_select_voltage), .busy(busy), .done(done),
      .pass(pass), .fail_addr(fail_addr), .id_maker(id_maker), .id_type(id_type));
   eps_rom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DEV_TYPE)) eps_rom_model_inst (.clk(clk),
      .addr(addr_out), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .prog_data(data_o),
      .prog_oe(data_oe), .bus_level(data_i), .vcc_prog(vcc_prog), .vpp_on(vpp_on),
      .hv_id(id_select_voltage), .n_bad(n_bad), .n_pulses(n_pulses), .last_addr(last_addr));
   // ==========================================================
   // Monitors and timeout
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (!chip_en_n && vpp_on && (!data_oe || data_o !== (addr_out[7:0] ^ 8'h5A)))
         bad_data <= bad_data + 1;
      if (id_select_voltage && (addr_out & 20'hFFDFE) != 20'h00000)
         bad_id <= bad_id + 1;
      if (!out_en_n)
         n_reads <= n_reads + 1;
   end
   always @(negedge clk)
   begin
      if (cycles == LIMIT)
      begin
         n_fail++;
         summarize();
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic summarize;
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_done(input int bound, output logic seen);
      int k;
      seen = 1'b0;
      for (k = 0; k < bound && !seen; k++)
      begin
         @(negedge clk);
         seen = (done === 1'b1);
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_reset;
      check(chip_en_n === 1'b1 && out_en_n === 1'b1 && data_oe === 1'b0 && vpp_on === 1'b0
         && vcc_prog === 1'b0 && id_select_voltage === 1'b0 && busy === 1'b0
         && done === 1'b0, "idle outputs after reset");
      check(pass === 1'b0 && fail_addr === 20'h00000, "results cleared");
   endtask
   task automatic test_id;
      logic seen;
      @(negedge clk);
      start_id = 1'b1;
      @(negedge clk);
      start_id = 1'b0;
      check(busy === 1'b1, "busy after id start");
      wait_done(2000, seen);
      check(seen === 1'b1, "id read finished");
      check(id_maker === MAKER, "maker byte");
      check(id_type === DEV_TYPE, "device type byte");
      check(bad_id == 0 && n_bad == 0, "id address lines low");
      @(negedge clk);
      check(done === 1'b0 && busy === 1'b0, "done lasts one cycle");
   endtask
   task automatic test_prog;
      int k;
      int reads0;
      @(negedge clk);
      start_prog = 1'b1;
      @(negedge clk);
      start_prog = 1'b0;
      for (k = 0; k < 1000 && vcc_prog !== 1'b1; k++)
         @(negedge clk);
      check(vcc_prog === 1'b1 && vpp_on === 1'b0, "supply before vpp");
      for (k = 0; k < 1000 && vpp_on !== 1'b1; k++)
         @(negedge clk);
      check(vpp_on === 1'b1 && chip_en_n === 1'b1, "vpp up before pulse");
      reads0 = n_reads;
      for (k = 0; k < 8000 && n_pulses < 1; k++)
         @(negedge clk);
      check(n_pulses == 1 && last_addr === 20'h00000, "first pulse at lowest");
      for (k = 0; k < 8000 && n_pulses < 2; k++)
         @(negedge clk);
      check(n_pulses == 2 && last_addr === 20'h00001, "second pulse next address");
      check(n_reads == reads0, "no verify read in first pass");
      check(n_bad == 0, "pulse width and supply order");
      check(bad_data == 0, "data held during pulse");
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      test_reset();
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      test_reset();
      test_id();
      test_prog();
      test_id();
      summarize();
   end
endmodule
